// ---- rtl/lcgs_top.sv ----
// Gate three and four term selection with an AHB-Lite register file.
//
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "lcgs_params.svh"
//
// Overview of operation
// - Gate three true enables pass data lines.
// - Gate three inverted enables pass negated lines.
// - Gate four true enables pass data lines.
// - Gate four inverted enables pass negated lines.
// - Term enables are readable and writable.
// - Mirror bits 0-3 copy cell outputs.
// - Mirror bits 7-4 read zero, ignore writes.
// - Three-bit fields pick one of eight inputs.
//
// The slave answers every transfer at once, with no wait states. Read
// data is loaded at the edge that takes the address phase and stands
// through the data phase. A write lands at the edge that closes its
// data phase. Both gate outputs are registered, so they follow the
// registers and the cell inputs one clock later. The mirror is a
// registered copy of the cell outputs, so a read returns them as they
// stood at the clock edge before its address phase was taken.
module lcgs_top
  import lcgs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] cell_in,
  input wire logic [3:0] cell_out,
  output logic gate_three_in,
  output logic gate_four_in
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Picks one cell input from a window of eight starting at base.
  function automatic logic pick(input logic [15:0] vec,
                                input logic [3:0] base,
                                input logic [2:0] code);
    logic [3:0] idx;
    // The window wraps past input 15, which data four relies on.
    idx = base + {1'b0, code};
    return vec[idx];
  endfunction

  // ORs every enabled true or inverted term of the four data lines.
  function automatic logic gate_or(input lcgs_terms_t en,
                                   input logic [3:0] d);
    logic [7:0] terms;
    // Term order matches the enable bits, bit 7 down to bit 0.
    terms = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
    return |(en & terms);
  endfunction

  // ----------------------------------------------------------------
  // Registers and bus state
  // ----------------------------------------------------------------
  // Selects and term enables reset to zero, a known start state.
  logic [7:0] data_select_low; // Data 1 and 2 selection codes.
  logic [7:0] data_select_high; // Data 3 and 4 selection codes.
  lcgs_terms_t gate_three_terms; // Term enables of gate three.
  lcgs_terms_t gate_four_terms; // Term enables of gate four.
  logic [3:0] cell_output_mirror; // Sampled copy of the cell outputs.
  lcgs_aphase_t aphase; // Address phase held for the data phase.

  // Next values of the registers.
  logic [7:0] next_sel_low;
  logic [7:0] next_sel_high;
  lcgs_terms_t next_gate_three;
  lcgs_terms_t next_gate_four;
  lcgs_aphase_t next_aphase;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------

  // A transfer starts on a selected NONSEQ or SEQ with the bus ready.
  wire logic start = hsel & hready & htrans[1];
  // Write strobes of the data phase, one per writable register.
  wire logic wr_phase = aphase.valid & aphase.write;
  wire logic wr_sel_low = wr_phase & (aphase.addr == `LCGS_OFF_SEL_LOW);
  wire logic wr_sel_high = wr_phase & (aphase.addr == `LCGS_OFF_SEL_HIGH);
  wire logic wr_g3 = wr_phase & (aphase.addr == `LCGS_OFF_GATE_THREE);
  wire logic wr_g4 = wr_phase & (aphase.addr == `LCGS_OFF_GATE_FOUR);
  // Only the low byte lane carries register data.
  wire logic [7:0] wbyte = hwdata[7:0];

  // The slave never stretches a transfer and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign next_aphase = '{valid: start, write: hwrite, addr: haddr[7:0]};

  // Unimplemented selection bits 7 and 3 are masked away on writes.
  assign next_sel_low = wr_sel_low ? (wbyte & `LCGS_SEL_MASK)
                                   : data_select_low;
  assign next_sel_high = wr_sel_high ? (wbyte & `LCGS_SEL_MASK)
                                     : data_select_high;
  assign next_gate_three = wr_g3 ? lcgs_terms_t'(wbyte) : gate_three_terms;
  assign next_gate_four = wr_g4 ? lcgs_terms_t'(wbyte) : gate_four_terms;

  // Read data uses next values so a read right after a write sees it.
  wire logic [7:0] rd_addr = haddr[7:0];
  wire logic [7:0] rd_byte =
    (rd_addr == `LCGS_OFF_SEL_LOW) ? next_sel_low :
    (rd_addr == `LCGS_OFF_SEL_HIGH) ? next_sel_high :
    (rd_addr == `LCGS_OFF_GATE_THREE) ? 8'(next_gate_three) :
    (rd_addr == `LCGS_OFF_GATE_FOUR) ? 8'(next_gate_four) :
    (rd_addr == `LCGS_OFF_MIRROR) ? {4'h0, cell_output_mirror} :
    // Unmapped offsets read zero.
    8'h00;

  // ----------------------------------------------------------------
  // Data line selection
  // ----------------------------------------------------------------
  // Data four wraps from input 15 back to input 0.
  // eight-way input pick
  wire logic sel_data_one = pick(cell_in, `LCGS_BASE_D1,
                                 data_select_low[2:0]);
  wire logic sel_data_two = pick(cell_in, `LCGS_BASE_D2,
                                 data_select_low[6:4]);
  wire logic sel_data_three = pick(cell_in, `LCGS_BASE_D3,
                                   data_select_high[2:0]);
  wire logic sel_data_four = pick(cell_in, `LCGS_BASE_D4,
                                  data_select_high[6:4]);
  wire logic [3:0] sel_data = {sel_data_four, sel_data_three,
                               sel_data_two, sel_data_one};

  // ----------------------------------------------------------------
  // Gates
  // ----------------------------------------------------------------
  // Both gates see the same four data lines; only the enables differ.
  // gate three OR
  wire logic next_gate_three_in = gate_or(gate_three_terms, sel_data);
  wire logic next_gate_four_in = gate_or(gate_four_terms, sel_data);

  // ----------------------------------------------------------------
  // Clocked state
  // ----------------------------------------------------------------

  // Bus state and read data.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aphase <= '0;
      hrdata <= 32'h0000_0000;
    end else begin
      aphase <= next_aphase;
      // Read data loads only when a read address phase is taken.
      hrdata <= (start && !hwrite) ? {24'h00_0000, rd_byte} : hrdata;
    end
  end

  // Configuration registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_select_low <= `LCGS_RST_SEL;
      data_select_high <= `LCGS_RST_SEL;
      gate_three_terms <= `LCGS_RST_TERMS;
      gate_four_terms <= `LCGS_RST_TERMS;
    end else begin
      // A write lands at the edge that closes its data phase.
      data_select_low <= next_sel_low;
      data_select_high <= next_sel_high;
      gate_three_terms <= next_gate_three;
      gate_four_terms <= next_gate_four;
    end
  end

  // Gate outputs and the output mirror.
  // Registering the outputs gives the rest of the cell clean levels.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_three_in <= 1'b0;
      gate_four_in <= 1'b0;
      cell_output_mirror <= `LCGS_RST_MIRROR;
    end else begin
      gate_three_in <= next_gate_three_in;
      gate_four_in <= next_gate_four_in;
      cell_output_mirror <= cell_out;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Every property below is off while reset is held.

  // A read address phase to the mirror.
  sequence mirror_read;
    start && !hwrite && (haddr[7:0] == `LCGS_OFF_MIRROR);
  endsequence

  // A write data phase to gate three.
  sequence g3_write;
    wr_g3;
  endsequence

  // A read address phase to any offset.
  sequence any_read;
    start && !hwrite;
  endsequence

  g3_true_a: assert property (
    gate_three_terms.d1_true_en && sel_data_one |=> gate_three_in)
    else $error("gate three true term lost");
  g3_true_d4_a: assert property (
    gate_three_terms.d4_true_en && sel_data_four |=> gate_three_in)
    else $error("gate three data four term lost");
  g3_inverted_a: assert property (
    gate_three_terms.d4_inv_en && !sel_data_four |=> gate_three_in)
    else $error("gate three inverted term lost");
  g3_inv_d1_a: assert property (
    gate_three_terms.d1_inv_en && !sel_data_one |=> gate_three_in)
    else $error("gate three data one inverted term lost");
  g4_true_a: assert property (
    gate_four_terms.d3_true_en && sel_data_three |=> gate_four_in)
    else $error("gate four true term lost");
  g4_true_d1_a: assert property (
    gate_four_terms.d1_true_en && sel_data_one |=> gate_four_in)
    else $error("gate four data one term lost");
  g4_true_d4_a: assert property (
    gate_four_terms.d4_true_en && sel_data_four |=> gate_four_in)
    else $error("gate four data four term lost");
  g4_inverted_a: assert property (
    gate_four_terms.d2_inv_en && !sel_data_two |=> gate_four_in)
    else $error("gate four inverted term lost");
  g4_inv_d1_a: assert property (
    gate_four_terms.d1_inv_en && !sel_data_one |=> gate_four_in)
    else $error("gate four data one inverted term lost");
  g3_readback_a: assert property (
    g3_write |=> 8'(gate_three_terms) == $past(hwdata[7:0]))
    else $error("gate three write not stored");
  g4_readback_a: assert property (
    wr_g4 |=> 8'(gate_four_terms) == $past(hwdata[7:0]))
    else $error("gate four write not stored");
  mirror_copy_a: assert property (
    mirror_read |=> hrdata[3:0] == $past(cell_output_mirror))
    else $error("mirror read wrong");
  mirror_follow_a: assert property (
    hresetn |=> cell_output_mirror == $past(cell_out))
    else $error("mirror does not follow cells");
  mirror_upper_a: assert property (
    mirror_read |=> hrdata[31:4] == 28'h000_0000)
    else $error("mirror upper bits not zero");
  read_upper_a: assert property (
    any_read |=> hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");
  select_code_a: assert property (
    data_select_low[2:0] == 3'h5 && cell_in[5] &&
    8'(gate_three_terms) == 8'h02 |=> gate_three_in)
    else $error("data one selection wrong");
  select_wrap_a: assert property (
    data_select_high[6:4] == 3'h4 && cell_in[0] &&
    8'(gate_three_terms) == 8'h80 |=> gate_three_in)
    else $error("data four selection wrong");
  sel_unused_a: assert property (
    !data_select_low[7] && !data_select_low[3] &&
    !data_select_high[7] && !data_select_high[3])
    else $error("unused select bits set");
  empty_gate_a: assert property (
    8'(gate_four_terms) == 8'h00 |=> !gate_four_in [*1])
    else $error("empty gate not zero");
  empty_g3_a: assert property (
    8'(gate_three_terms) == 8'h00 |=> !gate_three_in)
    else $error("empty gate three not zero");

endmodule

// ---- inc/lcgs_params.svh ----
// Constants for the logic cell gate select block.
`ifndef LCGS_PARAMS_SVH
`define LCGS_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define LCGS_OFF_SEL_LOW 8'h00
`define LCGS_OFF_SEL_HIGH 8'h04
`define LCGS_OFF_GATE_THREE 8'h08
`define LCGS_OFF_GATE_FOUR 8'h0C
`define LCGS_OFF_MIRROR 8'h10

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define LCGS_SEL_LO_POS 0
`define LCGS_SEL_HI_POS 4
`define LCGS_SEL_MASK 8'h77
`define LCGS_MIRROR_MASK 8'h0F
`define LCGS_BASE_D1 4'h0
`define LCGS_BASE_D2 4'h4
`define LCGS_BASE_D3 4'h8
`define LCGS_BASE_D4 4'hC

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LCGS_RST_SEL 8'h00
`define LCGS_RST_TERMS 8'h00
`define LCGS_RST_MIRROR 4'h0

`endif

// ---- inc/lcgs_pkg.sv ----
// Types shared by the logic cell gate select block.
package lcgs_pkg;

  // ----------------------------------------------------------------
  // Term enables of one gate, bit 7 down to bit 0.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic d4_true_en;
    logic d4_inv_en;
    logic d3_true_en;
    logic d3_inv_en;
    logic d2_true_en;
    logic d2_inv_en;
    logic d1_true_en;
    logic d1_inv_en;
  } lcgs_terms_t;

  // Captured AHB address phase.
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } lcgs_aphase_t;

endpackage

// ---- tb/lcgs_top_tb.sv ----
// Self-checking testbench for the gate select block.
`timescale 1ns/10ps
`include "lcgs_params.svh"
module lcgs_top_tb
  import lcgs_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and stimulus table
  // ----------------------------------------------------------------
  // One row: register settings, cell inputs and the gate results due.
  typedef struct packed {
    logic [7:0] sel_lo;
    logic [7:0] sel_hi;
    lcgs_terms_t g3;
    lcgs_terms_t g4;
    logic [15:0] cin;
    logic e3;
    logic e4;
  } lcgs_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic gate_three_in, gate_four_in;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] cell_in;
  logic [3:0] cell_out;
  int fail_count, n_tests;
  // Register offsets in map order, select registers first.
  logic [7:0] offs [5] = '{`LCGS_OFF_SEL_LOW, `LCGS_OFF_SEL_HIGH,
    `LCGS_OFF_GATE_THREE, `LCGS_OFF_GATE_FOUR, `LCGS_OFF_MIRROR};
  // Each row exercises one select field at a boundary code, at code 5, or a mix.
  lcgs_row_t rows [14] = '{
    '{8'h05, 8'h00, 8'h02, 8'h01, 16'h0020, 1'b1, 1'b0},
    '{8'h00, 8'h00, 8'h04, 8'h08, 16'h0000, 1'b1, 1'b0},
    '{8'h00, 8'h00, 8'h10, 8'h20, 16'h0100, 1'b0, 1'b1},
    '{8'h00, 8'h00, 8'h01, 8'h02, 16'h0001, 1'b0, 1'b1},
    '{8'h00, 8'h00, 8'h02, 8'h01, 16'h0001, 1'b1, 1'b0},
    '{8'h00, 8'h00, 8'h02, 8'h01, 16'h0000, 1'b0, 1'b1},
    '{8'h07, 8'h00, 8'h02, 8'h00, 16'h0080, 1'b1, 1'b0},
    '{8'h70, 8'h00, 8'h08, 8'h04, 16'h0800, 1'b1, 1'b0},
    '{8'h00, 8'h05, 8'h20, 8'h10, 16'h0000, 1'b0, 1'b1},
    '{8'h00, 8'h40, 8'h80, 8'h40, 16'h0001, 1'b1, 1'b0},
    '{8'h00, 8'h30, 8'h40, 8'h80, 16'h8000, 1'b0, 1'b1},
    '{8'h00, 8'h00, 8'hFF, 8'h00, 16'h5A5A, 1'b1, 1'b0},
    '{8'h00, 8'h00, 8'hAA, 8'h55, 16'h1111, 1'b1, 1'b0},
    '{8'h00, 8'h00, 8'hAA, 8'h55, 16'h0000, 1'b0, 1'b1}};

  // The ready input is the slave's own ready output.
  lcgs_top lcgs_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cell_in(cell_in),
    .cell_out(cell_out), .gate_three_in(gate_three_in),
    .gate_four_in(gate_four_in));

  // Free-running bus clock at 100 ns period.
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic results();
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits for ready under a bound, so a stuck slave cannot hang us.
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        break;
    end
    if (i == 16) begin
      fail_count++;
      results();
    end
  endtask

  // One single word transfer; read data is taken at the data edge.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    q = hrdata;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    cell_in = 16'h0000;
    cell_out = 4'h0;
    fail_count = 0;
    n_tests = 0;
    repeat (8) @(posedge hclk);
    chk({31'h0, gate_three_in}, 32'h0000_0000);
    chk({31'h0, gate_four_in}, 32'h0000_0000);
    chk({31'h0, hreadyout}, 32'h0000_0001);
    chk({31'h0, hresp}, 32'h0000_0000);
    hresetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      xfer(1'b0, offs[k], 32'h0000_0000, rd);
      chk(rd, 32'h0000_0000);
    end
    // Table of ordinary cases: program, read back, drive, compare.
    foreach (rows[i]) begin
      xfer(1'b1, offs[0], {24'h00_0000, rows[i].sel_lo}, rd);
      xfer(1'b1, offs[1], {24'h00_0000, rows[i].sel_hi}, rd);
      xfer(1'b1, offs[2], {24'h00_0000, rows[i].g3}, rd);
      xfer(1'b1, offs[3], {24'h00_0000, rows[i].g4}, rd);
      xfer(1'b0, offs[2], 32'h0000_0000, rd);
      chk(rd, {24'h00_0000, rows[i].g3});
      xfer(1'b0, offs[3], 32'h0000_0000, rd);
      chk(rd, {24'h00_0000, rows[i].g4});
      cell_in <= rows[i].cin;
      repeat (3) @(posedge hclk);
      chk({31'h0, gate_three_in}, {31'h0, rows[i].e3});
      chk({31'h0, gate_four_in}, {31'h0, rows[i].e4});
    end
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, offs[k], 32'hFFFF_FFFF, rd);
      xfer(1'b0, offs[k], 32'h0000_0000, rd);
      chk(rd, 32'h0000_0077);
    end
    cell_out <= 4'hA;
    xfer(1'b1, offs[4], 32'hFFFF_FFFF, rd);
    xfer(1'b0, offs[4], 32'h0000_0000, rd);
    chk(rd, 32'h0000_000A);
    cell_out <= 4'h5;
    // The mirror flop takes the new cell outputs at the next edge.
    @(posedge hclk);
    xfer(1'b0, offs[4], 32'h0000_0000, rd);
    chk(rd, 32'h0000_0005);
    // An unmapped word reads zero and keeps no write.
    xfer(1'b1, 8'h14, 32'hFFFF_FFFF, rd);
    xfer(1'b0, 8'h14, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    // Second reset while gate four is high clears gate and terms.
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({31'h0, gate_four_in}, 32'h0000_0000);
    hresetn <= 1'b1;
    xfer(1'b0, offs[3], 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    results();
  end
endmodule
